// ==== core/pbm_pkg.sv ====
/*
 * Package for the burst-modulation, dead-band and fractional period block:
 * register offsets, field positions, reset values, states and the state record.
 * Assumes a 32-bit APB with byte addresses; every register is one aligned word.
 */
package pbm_pkg;

  // Register byte offsets
  localparam logic [7:0] PBM_MOD_CTRL_OFF = 8'h00;
  localparam logic [7:0] PBM_ASD_LEVEL_OFF = 8'h04;
  localparam logic [7:0] PBM_RISE_DB_OFF = 8'h08;
  localparam logic [7:0] PBM_FALL_DB_OFF = 8'h0C;
  localparam logic [7:0] PBM_FRAC_OFF = 8'h10;
  localparam logic [7:0] PBM_PERIOD_OFF = 8'h14;
  localparam logic [7:0] PBM_DUTY_OFF = 8'h18;
  localparam logic [7:0] PBM_STATUS_OFF = 8'h1C;

  // Modulation control fields
  localparam int PBM_MOD_EN_BIT = 0;
  localparam int PBM_MOD_SRC_LSB = 1;
  localparam int PBM_SW_BIT_POS = 4;
  localparam int PBM_FIXED_BIT = 5;

  // Modulation source codes
  localparam logic [2:0] PBM_SRC_PIN = 3'h0;
  localparam logic [2:0] PBM_SRC_CAPCMP0 = 3'h1;
  localparam logic [2:0] PBM_SRC_CAPCMP1 = 3'h2;
  localparam logic [2:0] PBM_SRC_CAPCMP2 = 3'h3;
  localparam logic [2:0] PBM_SRC_CAPCMP3 = 3'h4;
  localparam logic [2:0] PBM_SRC_CMP0 = 3'h5;
  localparam logic [2:0] PBM_SRC_CMP1 = 3'h6;
  localparam logic [2:0] PBM_SRC_SW = 3'h7;

  // Output level masks: full instance and the two-output instance
  localparam logic [5:0] PBM_MASK_FULL = 6'h3F;
  localparam logic [5:0] PBM_MASK_AB = 6'h03;

  // Status fields
  localparam int PBM_STAT_RUN_BIT = 0;
  localparam int PBM_STAT_ASD_BIT = 1;
  localparam int PBM_STAT_CNT_LSB = 16;

  typedef enum logic [1:0] {
    PBM_IDLE = 2'b00,
    PBM_RUN = 2'b01,
    PBM_STOP = 2'b10
  } pbm_state_e;

  typedef struct packed {
    logic mod_en;
    logic [2:0] mod_src;
    logic sw_bit;
    logic fixed_mode;
    logic [5:0] asd_level;
    logic [7:0] rise_db;
    logic [7:0] fall_db;
    logic [3:0] frac;
    logic [15:0] period;
    logic [15:0] duty;
    logic [15:0] tb_cnt;
    logic [3:0] frac_acc;
    logic stretch;
    logic toggle;
    logic raw;
    logic [7:0] db_cnt;
    pbm_state_e state;
    logic ext_s1;
    logic ext_s2;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic asd_s1;
    logic asd_s2;
    logic [5:0] out;
    logic pevent;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pbm_state_s;

  // Everything, registers included, comes out of reset at zero
  localparam pbm_state_s PBM_RESET = '0;

endpackage : pbm_pkg

// ==== core/pbm_burst_deadband.sv ====
/*
 * Burst modulation, dead band, fractional period and auto-shutdown levels
 * of one PWM controller channel, with its time base and an APB slave.
 * Assumes pclk is the PWM core clock; capture/compare inputs come from
 * logic on pclk, while the pin, comparator and shutdown inputs are async.
 */
// Functional notes
// - Enabled modulation source gates PWM running
// - Modulation disabled: PWM runs continuously
// - Exactly one selected modulation source
// - Software bit starts/stops bursts alone
// - Modulation start begins a fresh period
// - Non-fixed modes finish period, then freeze
// - Fixed duty stops at inactive period event
// - Shutdown level bit per output A-F
// - Two-output instance lacks levels C-F
// - Rising dead band, 8-bit clock count
// - Falling dead band, 8-bit clock count
// - Fractional count added to period events
// - Fraction step is one sixteenth clock
// - Period event on counter equals period
// - Period event clears time base counter
`timescale 1ns/1ns
`default_nettype none

module pbm_burst_deadband #(
  parameter bit TWO_OUTPUT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_modulation_input,
  input wire logic [3:0] capture_compare_unit,
  input wire logic [1:0] comparator_out,
  input wire logic auto_shutdown,
  output logic [5:0] pwm_out,
  output logic period_event
);
  import pbm_pkg::*;

  localparam logic [5:0] LVL_MASK = TWO_OUTPUT ? PBM_MASK_AB : PBM_MASK_FULL;

  pbm_state_s r_reg;
  pbm_state_s r_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic access;
    logic hit;
    logic wr;
    logic src_level;
    logic mod_on;
    logic match;
    logic [4:0] sum;
    logic ev;
    logic stop_now;
    logic raw_next;
    logic run_next;
    logic pri;
    logic cmp;
    logic [31:0] rd;
    access = 1'b0;
    hit = 1'b0;
    wr = 1'b0;
    src_level = 1'b0;
    mod_on = 1'b0;
    match = 1'b0;
    sum = 5'h00;
    ev = 1'b0;
    stop_now = 1'b0;
    raw_next = 1'b0;
    run_next = 1'b0;
    pri = 1'b0;
    cmp = 1'b0;
    rd = 32'h0000_0000;
    r_next = r_reg;

    // Two-stage synchronisers for the asynchronous inputs
    r_next.ext_s1 = external_modulation_input;
    r_next.ext_s2 = r_reg.ext_s1;
    r_next.cmp_s1 = comparator_out;
    r_next.cmp_s2 = r_reg.cmp_s1;
    r_next.asd_s1 = auto_shutdown;
    r_next.asd_s2 = r_reg.asd_s1;

    //////////////////////////////////////////////////////////////////////////
    // APB: answer one cycle into the access phase, so prdata is a flop
    access = psel & penable;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (access && !r_reg.pready) begin
      hit = 1'b1;
      unique case (paddr)
        PBM_MOD_CTRL_OFF: begin
          rd[PBM_MOD_EN_BIT] = r_reg.mod_en;
          rd[PBM_MOD_SRC_LSB +: 3] = r_reg.mod_src;
          rd[PBM_SW_BIT_POS] = r_reg.sw_bit;
          rd[PBM_FIXED_BIT] = r_reg.fixed_mode;
        end
        PBM_ASD_LEVEL_OFF: rd[5:0] = r_reg.asd_level;
        PBM_RISE_DB_OFF: rd[7:0] = r_reg.rise_db;
        PBM_FALL_DB_OFF: rd[7:0] = r_reg.fall_db;
        PBM_FRAC_OFF: rd[3:0] = r_reg.frac;
        PBM_PERIOD_OFF: rd[15:0] = r_reg.period;
        PBM_DUTY_OFF: rd[15:0] = r_reg.duty;
        PBM_STATUS_OFF: begin
          rd[PBM_STAT_RUN_BIT] = (r_reg.state != PBM_IDLE);
          rd[PBM_STAT_ASD_BIT] = r_reg.asd_s2;
          rd[PBM_STAT_CNT_LSB +: 16] = r_reg.tb_cnt;
        end
        default: hit = 1'b0;
      endcase
      r_next.pready = 1'b1;
      r_next.pslverr = ~hit;
      r_next.prdata = rd;
    end

    // Writes land only at the edge that completes the transfer
    wr = access & r_reg.pready & pwrite & ~r_reg.pslverr;
    if (wr) begin
      unique case (paddr)
        PBM_MOD_CTRL_OFF: begin
          // Every control is reloaded from pwdata, even when only the bit toggles
          r_next.mod_en = pwdata[PBM_MOD_EN_BIT];
          r_next.mod_src = pwdata[PBM_MOD_SRC_LSB +: 3];
          r_next.sw_bit = pwdata[PBM_SW_BIT_POS];
          r_next.fixed_mode = pwdata[PBM_FIXED_BIT];
        end
        PBM_ASD_LEVEL_OFF: r_next.asd_level = pwdata[5:0] & LVL_MASK;
        PBM_RISE_DB_OFF: r_next.rise_db = pwdata[7:0];
        PBM_FALL_DB_OFF: r_next.fall_db = pwdata[7:0];
        PBM_FRAC_OFF: r_next.frac = pwdata[3:0];
        PBM_PERIOD_OFF: r_next.period = pwdata[15:0];
        PBM_DUTY_OFF: r_next.duty = pwdata[15:0];
        default: r_next.frac = r_reg.frac;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Modulation source: one selection, never a combination
    unique case (r_reg.mod_src)
      PBM_SRC_PIN: src_level = r_reg.ext_s2;
      PBM_SRC_CAPCMP0: src_level = capture_compare_unit[0];
      PBM_SRC_CAPCMP1: src_level = capture_compare_unit[1];
      PBM_SRC_CAPCMP2: src_level = capture_compare_unit[2];
      PBM_SRC_CAPCMP3: src_level = capture_compare_unit[3];
      PBM_SRC_CMP0: src_level = r_reg.cmp_s2[0];
      PBM_SRC_CMP1: src_level = r_reg.cmp_s2[1];
      PBM_SRC_SW: src_level = r_reg.sw_bit;
    endcase
    // Disabled modulation ignores the source entirely
    mod_on = ~r_reg.mod_en | src_level;

    //////////////////////////////////////////////////////////////////////////
    // Time base; fraction dithers one extra clock on accumulator carry,
    // so the mean period grows by frac/16 clocks, not each single period
    match = (r_reg.tb_cnt == r_reg.period);
    sum = {1'b0, r_reg.frac_acc} + {1'b0, r_reg.frac};
    unique case (r_reg.state)
      PBM_IDLE: begin
        if (mod_on) begin
          r_next.state = PBM_RUN;
          r_next.tb_cnt = 16'h0000;
          r_next.frac_acc = 4'h0;
          r_next.stretch = 1'b0;
          r_next.toggle = 1'b1;
        end
      end
      PBM_RUN, PBM_STOP: begin
        if (match) begin
          if (r_reg.stretch) begin
            ev = 1'b1;
            r_next.stretch = 1'b0;
          end else begin
            r_next.frac_acc = sum[3:0];
            if (sum[4]) begin
              r_next.stretch = 1'b1;
            end else begin
              ev = 1'b1;
            end
          end
        end
        if (ev) begin
          r_next.tb_cnt = 16'h0000;
          r_next.toggle = ~r_reg.toggle;
        end else if (!match) begin
          r_next.tb_cnt = r_reg.tb_cnt + 16'h0001;
        end
        // Fixed duty freezes only on the event that turns it inactive
        stop_now = (~mod_on | (r_reg.state == PBM_STOP)) & ev &
                   (~r_reg.fixed_mode | r_reg.toggle);
        if (stop_now) begin
          r_next.state = PBM_IDLE;
        end else if (!mod_on) begin
          r_next.state = PBM_STOP;
        end else begin
          r_next.state = PBM_RUN;
        end
      end
      default: r_next.state = PBM_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Waveform and dead band
    run_next = (r_next.state != PBM_IDLE);
    raw_next = run_next & (r_reg.fixed_mode ? r_next.toggle : (r_next.tb_cnt < r_reg.duty));
    if (raw_next != r_reg.raw) begin
      r_next.db_cnt = raw_next ? r_reg.rise_db : r_reg.fall_db;
    end else if (r_reg.db_cnt != 8'h00) begin
      r_next.db_cnt = r_reg.db_cnt - 8'h01;
    end
    r_next.raw = raw_next;
    // Neither side on while the gap counts down
    pri = raw_next & (r_next.db_cnt == 8'h00);
    cmp = run_next & ~raw_next & (r_next.db_cnt == 8'h00);
    if (r_reg.asd_s2) begin
      r_next.out = r_reg.asd_level & LVL_MASK;
    end else begin
      // Frozen state drives every output inactive
      r_next.out = {cmp, pri, cmp, pri, cmp, pri} & LVL_MASK;
    end
    r_next.pevent = ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= PBM_RESET;
    end else if (pclk_en) begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign pwm_out = r_reg.out;
  assign period_event = r_reg.pevent;

endmodule : pbm_burst_deadband

`default_nettype wire

// ==== tb/pbm_properties.sv ====
/* Checker on the ports of pbm_burst_deadband, bound in at the foot.
   Assumes the pbm_pkg register map and pclk as the only clock. */
`timescale 1ns/1ns
`default_nettype none
module pbm_properties import pbm_pkg::*; #(parameter bit TWO_OUTPUT = 1'b0) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic auto_shutdown,
  input wire logic [5:0] pwm_out,
  input wire logic period_event
);
  logic [15:0] per_reg;
  logic [16:0] gap_reg;
  logic [4:0] asd_reg;
  logic mod_reg, frac_reg, dirty_reg;
  wire logic wr = pready && pwrite && pclk_en;
  // Sync chain plus output flop: outputs normal only after clean samples
  wire logic quiet = asd_reg == 5'h00 && !auto_shutdown;
  wire logic [16:0] len = {1'b0, per_reg} + 17'h00001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {per_reg, gap_reg, asd_reg, mod_reg, frac_reg} <= '0;
      dirty_reg <= 1'b1;
    end else begin
      asd_reg <= {asd_reg[3:0], auto_shutdown};
      if (wr && paddr == PBM_MOD_CTRL_OFF) mod_reg <= pwdata[PBM_MOD_EN_BIT];
      if (wr && paddr == PBM_PERIOD_OFF) per_reg <= pwdata[15:0];
      if (wr && paddr == PBM_FRAC_OFF) frac_reg <= pwdata[3:0] != 4'h0;
      if (pclk_en) gap_reg <= period_event ? 17'h00001 : gap_reg + 17'h00001;
      // Gap is only meaningful over a whole undisturbed free-running period
      if (pclk_en) dirty_reg <= (dirty_reg && !period_event) || wr || mod_reg;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && penable && !pready && pclk_en |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready && pclk_en |=> !pready)
    else $error("pready too long");
  a_unmapped_err: assert property (pready && paddr > PBM_STATUS_OFF |-> pslverr)
    else $error("unmapped access accepted");
  a_mapped_ok: assert property (pready && !pwrite && paddr[1:0] == 2'b00
    && paddr <= PBM_STATUS_OFF |-> !pslverr) else $error("mapped read refused");
  a_no_overlap: assert property (quiet |-> !(pwm_out[0] && pwm_out[1]))
    else $error("both outputs on");
  a_out_mirror: assert property (quiet |-> pwm_out[5:2] ==
    (TWO_OUTPUT ? 4'h0 : {2{pwm_out[1:0]}})) else $error("outputs C to F wrong");
  a_event_pulse: assert property (period_event && pclk_en && per_reg != 16'h0000
    |=> !period_event) else $error("period event too long");
  a_period_gap: assert property (period_event && pclk_en && !dirty_reg |->
    gap_reg == len || (frac_reg && gap_reg == len + 17'h00001)) else $error("period length");
  c_event: cover property (period_event && !dirty_reg);
  c_shutdown: cover property (!quiet && pwm_out != 6'h00);
  c_refused: cover property (pready && pslverr);
endmodule : pbm_properties
bind pbm_burst_deadband pbm_properties #(.TWO_OUTPUT(TWO_OUTPUT)) chk_u (.*);
`default_nettype wire

// ==== tb/pbm_power_stage.sv ====
/* Power stage model: switch pairs driven by pwm_out.
   Assumes bit pairs 1:0, 3:2 and 5:4 each drive the two switches of one leg. */
`timescale 1ns/1ns
`default_nettype none
module pbm_power_stage (
  input wire logic pclk,
  input wire logic [5:0] pwm_out,
  output logic [15:0] shoot_cnt
);
  logic [15:0] cnt_reg = 16'h0000;
  // Both switches of any leg on at once shorts the supply
  always @(posedge pclk) begin
    if ((pwm_out[0] && pwm_out[1]) || (pwm_out[2] && pwm_out[3]) ||
        (pwm_out[4] && pwm_out[5])) cnt_reg <= cnt_reg + 16'h0001;
  end
  assign shoot_cnt = cnt_reg;
endmodule : pbm_power_stage
`default_nettype wire

// ==== tb/pbm_burst_deadband_tb.sv ====
/* Self-checking bench for pbm_burst_deadband and a two-output copy.
   Assumes the pbm_pkg register map; pclk at 10 MHz. */
`timescale 1ns/1ns
`default_nettype none
module pbm_burst_deadband_tb;
  import pbm_pkg::*;
  localparam logic [31:0] MSK [4] = '{32'h3F, 32'hFF, 32'hFF, 32'h0F};
  logic pclk = 1'b0, presetn = 1'b0, pclk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, auto_shutdown = 1'b0, external_modulation_input = 1'b0;
  logic [3:0] capture_compare_unit = 4'h0;
  logic [1:0] comparator_out = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, prdata2, rd, rd2;
  logic [5:0] pwm_out, pwm_out2;
  logic pready, pslverr, period_event, err;
  logic [15:0] shoot_cnt;
  int mismatches = 0, num_checks = 0, i, n, g, p, f, dr, df, lv;
  initial forever #50 pclk = ~pclk;
  pbm_burst_deadband dut_u (.*);
  pbm_burst_deadband #(.TWO_OUTPUT(1'b1)) dut2_u (.*, .prdata(prdata2), .pready(),
    .pslverr(), .pwm_out(pwm_out2), .period_event());
  pbm_power_stage stage_u (.pclk(pclk), .pwm_out(pwm_out), .shoot_cnt(shoot_cnt));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Clocks spanned by a run of periods plus the carries the fraction adds
  function automatic int span(input int per, input int periods, input int fr);
    return periods * (per + 1) + fr;
  endfunction : span
  // Edges counted in n until the watched bit reaches v
  task automatic wait_on(input int k, input logic v, input int lim);
    logic [3:0] obs;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      obs = {pready, period_event, pwm_out[1:0]};
    end while (obs[k] !== v && n < lim);
    if (obs[k] !== v) begin
      chk("wait bound", 0, 1);
      report_and_stop();
    end
  endtask : wait_on
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    wait_on(3, 1'b1, 20);
    {rd, rd2, err} = {prdata, prdata2, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  // Unselected sources get the opposite level to prove they are ignored
  task automatic drive(input int s, input logic v, input logic fx);
    logic [6:0] t;
    t = {7{~v}};
    if (s < 7) t[s] = v;
    {comparator_out, capture_compare_unit, external_modulation_input} <= t;
    apb(1'b1, PBM_MOD_CTRL_OFF, {26'h0, fx, (s == 7) ? v : ~v, 3'(s), 1'b1});
  endtask : drive
  initial begin
    void'($urandom(32'hD8A7));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i + 4), 32'h0);
      chk("reset value", rd, 32'h0);
      g = $urandom;
      apb(1'b1, 8'(4 * i + 4), g);
      apb(1'b0, 8'(4 * i + 4), 32'h0);
      chk("readback", rd, g & MSK[i]);
    end
    apb(1'b1, PBM_ASD_LEVEL_OFF, 32'h3F);
    apb(1'b0, PBM_ASD_LEVEL_OFF, 32'h0);
    chk("two-output levels", rd2, 32'h03);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    p = 8 + $urandom % 12;
    dr = 1 + $urandom % 2;
    df = 1 + $urandom % 2;
    apb(1'b1, PBM_FRAC_OFF, 32'h0);
    apb(1'b1, PBM_RISE_DB_OFF, dr);
    apb(1'b1, PBM_FALL_DB_OFF, df);
    apb(1'b1, PBM_DUTY_OFF, p / 2);
    apb(1'b1, PBM_PERIOD_OFF, p);
    repeat (3) wait_on(2, 1'b1, 100);
    chk("period length", n, span(p, 1, 0));
    wait_on(1, 1'b1, 100);
    wait_on(1, 1'b0, 100);
    wait_on(0, 1'b1, 100);
    chk("rise gap", n >= dr && n <= dr + 1, 1);
    wait_on(0, 1'b0, 100);
    wait_on(1, 1'b1, 100);
    chk("fall gap", n >= df && n <= df + 1, 1);
    f = 1 + $urandom % 15;
    apb(1'b1, PBM_FRAC_OFF, f);
    wait_on(2, 1'b1, 100);
    g = 0;
    repeat (16) begin
      wait_on(2, 1'b1, 100);
      g += n;
    end
    chk("fraction sum", g, span(p, 16, f));
    apb(1'b1, PBM_FRAC_OFF, 32'h0);
    for (i = 0; i < 16; i++) begin
      drive(i % 8, 1'b0, 1'(i / 8));
      wait_on(2, 1'b1, 2 * p + 12);
      repeat (2 * p + 12) @(posedge pclk);
      chk("held off", pwm_out, 32'h0);
      apb(1'b0, PBM_STATUS_OFF, 32'h0);
      chk("frozen", rd[PBM_STAT_RUN_BIT], 1'b0);
      drive(i % 8, 1'b1, 1'(i / 8));
      wait_on(2, 1'b1, p + 12);
      chk("fresh period", n > p - 4, 1);
    end
    apb(1'b1, PBM_MOD_CTRL_OFF, 32'h0);
    repeat (2 * p) @(posedge pclk);
    apb(1'b0, PBM_STATUS_OFF, 32'h0);
    chk("continuous", rd[PBM_STAT_RUN_BIT], 1'b1);
    chk("shoot-through", shoot_cnt, 32'h0);
    // Frozen edges must not count: the period seen after them stays whole
    wait_on(2, 1'b1, 100);
    pclk_en <= 1'b0;
    repeat (5) @(posedge pclk);
    pclk_en <= 1'b1;
    wait_on(2, 1'b1, 100);
    chk("enable freeze", n, span(p, 1, 0));
    lv = $urandom % 64;
    apb(1'b1, PBM_ASD_LEVEL_OFF, lv);
    auto_shutdown <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("shutdown level", pwm_out, lv);
    chk("shutdown two", pwm_out2, lv & 3);
    apb(1'b0, PBM_STATUS_OFF, 32'h0);
    chk("shutdown status", rd[PBM_STAT_ASD_BIT], 1'b1);
    auto_shutdown <= 1'b0;
    repeat (6) @(posedge pclk);
    report_and_stop();
  end
endmodule : pbm_burst_deadband_tb
`default_nettype wire
